// >>> hdl/ipt_top.v
// Ignition period timer, 24-bit real-time clock, button inputs and
// register slave for the engine speed indicator.
// Assumes an Avalon-MM master using word addresses and synchronous inputs.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ipt_defs.vh"

// Functional notes
// - Timers advance once per eight clocks
// - 16-bit period timer between rising edges
// - Overflow aborts; restart at next rising edge
// - Clock: low timer plus two stored bytes
// - Low timer overflow carries into upper bytes
// - Mux and flash rates from clock bits
// - Seven segment lines plus shift lamp output
// - Only selected digit anode powered, pattern shown
// - Two selects, one digit powered at once
// - Config button press requests config mode
// - Select button polled while configuring
// - Comparator high when sense exceeds reference
// - Comparator edges drive period start and stop
// - Middle bit 5 picks thousands or hundreds
// - Upper bit 2 low blanks flashing digit
// - Middle bit 7 flashes enabled shift lamp
// - Flash enables and lamp-on bit stored
module ipt_top (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [5:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   input wire [7:0] i_ignition_sense_input,
   input wire [7:0] i_comparator_reference_input,
   input wire i_config_button_input_n,
   input wire i_select_button_input_n,
   output wire [6:0] o_segment_n,
   output wire o_shift_lamp_output,
   output wire o_digit_one_select,
   output wire o_digit_two_select,
   output wire o_config_request,
   output wire o_config_mode
);

   reg ack_reg;
   reg [2:0] prescale_reg;
   reg tick_reg;
   reg comp_reg;
   reg comp_prev_reg;
   reg measuring_reg;
   reg [15:0] period_timer_reg;
   reg [15:0] period_reg;
   reg period_valid_reg;
   reg overflow_abort_reg;
   reg comp_edge_reg;
   reg [7:0] clock_low_timer_reg;
   reg [7:0] clock_middle_reg;
   reg [7:0] clock_upper_reg;
   reg [7:0] flash_state_reg;
   reg [6:0] thousands_seg_reg;
   reg [6:0] hundreds_seg_reg;
   reg config_btn_prev_reg;
   reg config_request_reg;
   reg config_mode_reg;
   reg [31:0] read_next;

   wire access;
   wire wr_take;
   wire comp_rise;
   wire period_overflow;
   wire low_overflow;
   wire [15:0] middle_upper;
   wire [15:0] middle_upper_next;
   wire config_press;
   wire wr_ctrl;
   wire wr_status;
   wire wr_flash;
   wire wr_upper;
   wire wr_middle;
   wire wr_thou;
   wire wr_hund;
   wire [7:0] status_value;

   // Every access waits one cycle, then completes with waitrequest low
   assign access = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = access & ~ack_reg;
   assign wr_take = i_avs_write & ack_reg;

   always @(posedge i_clk)
   begin
      if (i_sys_rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= access & ~ack_reg;
   end

   // Write strobes, one per writable register
   assign wr_ctrl = wr_take & (i_avs_address == `IPT_IDX_CTRL);
   assign wr_status = wr_take & (i_avs_address == `IPT_IDX_STATUS);
   assign wr_flash = wr_take & (i_avs_address == `IPT_IDX_DISPLAY_FLASH_STATE);
   assign wr_upper = wr_take & (i_avs_address == `IPT_IDX_CLOCK_UPPER_BYTE);
   assign wr_middle = wr_take & (i_avs_address == `IPT_IDX_CLOCK_MIDDLE_BYTE);
   assign wr_thou = wr_take & (i_avs_address == `IPT_IDX_THOUSANDS_SEG);
   assign wr_hund = wr_take & (i_avs_address == `IPT_IDX_HUNDREDS_SEG);

   // Prescaler: one timer tick every eight clocks
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         prescale_reg <= 3'h0;
         tick_reg <= 1'b0;
      end
      else
      begin
         prescale_reg <= prescale_reg + 3'h1;
         tick_reg <= (prescale_reg == `IPT_PRESCALE_LAST);
      end
   end

   // Digital comparator on the sampled ignition and reference levels
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         comp_reg <= 1'b0;
         comp_prev_reg <= 1'b0;
      end
      else
      begin
         comp_reg <= (i_ignition_sense_input > i_comparator_reference_input);
         comp_prev_reg <= comp_reg;
      end
   end

   assign comp_rise = comp_reg & ~comp_prev_reg;
   assign period_overflow = measuring_reg & tick_reg &
      (period_timer_reg == `IPT_PERIOD_MAX);

   // Period measurement; a stopping edge also starts the next period
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         measuring_reg <= 1'b0;
         period_timer_reg <= 16'h0000;
         period_reg <= 16'h0000;
      end
      else if (comp_rise)
      begin
         if (measuring_reg)
            period_reg <= period_timer_reg;
         measuring_reg <= 1'b1;
         period_timer_reg <= 16'h0000;
      end
      else if (period_overflow)
      begin
         // Below range: drop this one and wait for a fresh edge
         measuring_reg <= 1'b0;
         period_timer_reg <= 16'h0000;
      end
      else if (measuring_reg & tick_reg)
         period_timer_reg <= period_timer_reg + 16'h0001;
   end

   // Sticky events; a new event beats a clear in the same cycle
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         period_valid_reg <= 1'b0;
         overflow_abort_reg <= 1'b0;
         comp_edge_reg <= 1'b0;
      end
      else
      begin
         if (comp_rise & measuring_reg)
            period_valid_reg <= 1'b1;
         else if (wr_status & i_avs_writedata[`IPT_ST_PERIOD_VALID])
            period_valid_reg <= 1'b0;
         if (period_overflow & ~comp_rise)
            overflow_abort_reg <= 1'b1;
         else if (wr_status & i_avs_writedata[`IPT_ST_OVERFLOW_ABORT])
            overflow_abort_reg <= 1'b0;
         if (comp_rise)
            comp_edge_reg <= 1'b1;
         else if (wr_status & i_avs_writedata[`IPT_ST_COMPARATOR_EDGE])
            comp_edge_reg <= 1'b0;
      end
   end

   // Real-time clock: low timer free running, carry into stored bytes
   assign low_overflow = tick_reg & (clock_low_timer_reg == 8'hff);
   assign middle_upper = {clock_upper_reg, clock_middle_reg};
   assign middle_upper_next = middle_upper + 16'h0001;

   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         clock_low_timer_reg <= `IPT_BYTE_RESET;
         clock_middle_reg <= `IPT_BYTE_RESET;
         clock_upper_reg <= `IPT_BYTE_RESET;
      end
      else
      begin
         if (tick_reg)
            clock_low_timer_reg <= clock_low_timer_reg + 8'h01;
         // A software write to a stored byte wins over the carry
         if (wr_middle)
            clock_middle_reg <= i_avs_writedata[7:0];
         else if (low_overflow)
            clock_middle_reg <= middle_upper_next[7:0];
         if (wr_upper)
            clock_upper_reg <= i_avs_writedata[7:0];
         else if (low_overflow)
            clock_upper_reg <= middle_upper_next[15:8];
      end
   end

   // Display registers written by software
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         flash_state_reg <= `IPT_BYTE_RESET;
         thousands_seg_reg <= `IPT_SEG_RESET;
         hundreds_seg_reg <= `IPT_SEG_RESET;
      end
      else
      begin
         if (wr_flash)
            flash_state_reg <= i_avs_writedata[7:0] & `IPT_DS_MASK;
         if (wr_thou)
            thousands_seg_reg <= i_avs_writedata[6:0];
         if (wr_hund)
            hundreds_seg_reg <= i_avs_writedata[6:0];
      end
   end

   // Config button: a press (falling level) raises a sticky request
   assign config_press = config_btn_prev_reg & ~i_config_button_input_n;

   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         config_btn_prev_reg <= 1'b1;
         config_request_reg <= 1'b0;
         config_mode_reg <= 1'b0;
      end
      else
      begin
         config_btn_prev_reg <= i_config_button_input_n;
         if (config_press)
            config_request_reg <= 1'b1;
         else if (wr_status & i_avs_writedata[`IPT_ST_CONFIG_REQUEST])
            config_request_reg <= 1'b0;
         // The press enters config mode; software leaves it by writing zero
         if (config_press)
            config_mode_reg <= 1'b1;
         else if (wr_ctrl)
            config_mode_reg <= i_avs_writedata[`IPT_CTRL_CONFIG_MODE];
      end
   end

   assign o_config_request = config_request_reg;
   assign o_config_mode = config_mode_reg;

   // Select button is a plain level that software polls, no event logic
   assign status_value = {1'b0, comp_reg, measuring_reg,
      ~i_select_button_input_n, comp_edge_reg, config_request_reg,
      overflow_abort_reg, period_valid_reg};

   // Read mux; unmapped indices read zero
   always @*
   begin
      read_next = 32'h0000_0000;
      if (i_avs_address == `IPT_IDX_CTRL)
         read_next = {31'h0000_0000, config_mode_reg};
      else if (i_avs_address == `IPT_IDX_STATUS)
         read_next = {24'h00_0000, status_value};
      else if (i_avs_address == `IPT_IDX_PERIOD)
         read_next = {16'h0000, period_reg};
      else if (i_avs_address == `IPT_IDX_CLOCK_LOW)
         read_next = {24'h00_0000, clock_low_timer_reg};
      else if (i_avs_address == `IPT_IDX_THOUSANDS_SEG)
         read_next = {25'h000_0000, thousands_seg_reg};
      else if (i_avs_address == `IPT_IDX_HUNDREDS_SEG)
         read_next = {25'h000_0000, hundreds_seg_reg};
      else if (i_avs_address == `IPT_IDX_DISPLAY_FLASH_STATE)
         read_next = {24'h00_0000, flash_state_reg};
      else if (i_avs_address == `IPT_IDX_CLOCK_UPPER_BYTE)
         read_next = {24'h00_0000, clock_upper_reg};
      else if (i_avs_address == `IPT_IDX_CLOCK_MIDDLE_BYTE)
         read_next = {24'h00_0000, clock_middle_reg};
   end

   // Read data is captured in the wait cycle and stands while ack is high
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_avs_readdata <= 32'h0000_0000;
      else if (i_avs_read & ~ack_reg)
         o_avs_readdata <= read_next;
   end

   // Display driver
   ipt_display_mux u_display (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clock_upper(clock_upper_reg),
      .i_clock_middle(clock_middle_reg),
      .i_flash_state(flash_state_reg),
      .i_thousands_seg(thousands_seg_reg),
      .i_hundreds_seg(hundreds_seg_reg),
      .o_segment_n(o_segment_n),
      .o_shift_lamp_output(o_shift_lamp_output),
      .o_digit_one_select(o_digit_one_select),
      .o_digit_two_select(o_digit_two_select)
   );

endmodule // ipt_top

// >>> inc/ipt_defs.vh
// Constants for the ignition period timer and display multiplexer.
// Assumes the includer uses word indices on the register bus.
`ifndef IPT_DEFS_VH
`define IPT_DEFS_VH

// Register word indices (byte address is four times the index)
`define IPT_IDX_CTRL 6'h00
`define IPT_IDX_STATUS 6'h01
`define IPT_IDX_PERIOD 6'h02
`define IPT_IDX_CLOCK_LOW 6'h03
`define IPT_IDX_THOUSANDS_SEG 6'h04
`define IPT_IDX_HUNDREDS_SEG 6'h05
`define IPT_IDX_DISPLAY_FLASH_STATE 6'h0d
`define IPT_IDX_CLOCK_UPPER_BYTE 6'h0e
`define IPT_IDX_CLOCK_MIDDLE_BYTE 6'h0f

// Control register fields
`define IPT_CTRL_CONFIG_MODE 0

// Status register fields
`define IPT_ST_PERIOD_VALID 0
`define IPT_ST_OVERFLOW_ABORT 1
`define IPT_ST_CONFIG_REQUEST 2
`define IPT_ST_COMPARATOR_EDGE 3
`define IPT_ST_SELECT_PRESSED 4
`define IPT_ST_MEASURING 5
`define IPT_ST_COMPARATOR_LEVEL 6
`define IPT_ST_W1C_MASK 8'h0f

// Display flash state fields
`define IPT_DS_LEFT_FLASH 3
`define IPT_DS_RIGHT_FLASH 4
`define IPT_DS_SHIFT_FLASH 5
`define IPT_DS_SHIFT_ON 7
`define IPT_DS_MASK 8'hb8

// Clock bits that time the display
`define IPT_MUX_BIT 5
`define IPT_FLASH_BIT 2
`define IPT_SHIFT_FLASH_BIT 7

// Timer prescale: timers count once every eight oscillator clocks
`define IPT_TICK_DIV 4'h8
`define IPT_PRESCALE_LAST 3'h7

// Reset values and period timer limit
`define IPT_SEG_RESET 7'h7f
`define IPT_BYTE_RESET 8'h00
`define IPT_PERIOD_MAX 16'hffff

`endif

// >>> hdl/ipt_display_mux.v
// Display multiplexer: picks the active digit, blanks flashing digits
// and drives the shift lamp. Assumes common anode digits, active low
// segment cathodes and active high anode transistor drive.
`timescale 1ns/1ps
`include "ipt_defs.vh"

module ipt_display_mux (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [7:0] i_clock_upper,
   input wire [7:0] i_clock_middle,
   input wire [7:0] i_flash_state,
   input wire [6:0] i_thousands_seg,
   input wire [6:0] i_hundreds_seg,
   output reg [6:0] o_segment_n,
   output reg o_shift_lamp_output,
   output reg o_digit_one_select,
   output reg o_digit_two_select
);

   wire right_active;
   wire flash_off_phase;
   wire digit_blank;
   wire shift_lit;
   wire [6:0] pattern;
   wire [6:0] seg_next;

   // Middle clock bit picks thousands at 0, hundreds at 1
   assign right_active = i_clock_middle[`IPT_MUX_BIT];
   assign flash_off_phase = ~i_clock_upper[`IPT_FLASH_BIT];
   assign digit_blank = flash_off_phase &
      (right_active ? i_flash_state[`IPT_DS_RIGHT_FLASH] :
      i_flash_state[`IPT_DS_LEFT_FLASH]);
   assign pattern = right_active ? i_hundreds_seg : i_thousands_seg;
   // Lamp follows a faster clock bit only while flashing is enabled
   assign shift_lit = i_flash_state[`IPT_DS_SHIFT_ON] &
      (~i_flash_state[`IPT_DS_SHIFT_FLASH] | i_clock_middle[`IPT_SHIFT_FLASH_BIT]);

   // Per segment: a blanked digit leaves every cathode high
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1)
      begin : g_seg
         assign seg_next[g] = pattern[g] | digit_blank;
      end
   endgenerate

   // Registered outputs keep glitches off the transistor drives
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_segment_n <= `IPT_SEG_RESET;
         o_shift_lamp_output <= 1'b0;
         o_digit_one_select <= 1'b0;
         o_digit_two_select <= 1'b0;
      end
      else
      begin
         o_segment_n <= seg_next;
         o_shift_lamp_output <= shift_lit;
         o_digit_one_select <= ~right_active & ~digit_blank;
         o_digit_two_select <= right_active & ~digit_blank;
      end
   end

endmodule // ipt_display_mux

// >>> testbench/ipt_partner.sv
// Far side model: ignition coil level, reference divider, two buttons.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module ipt_partner (
   input wire logic i_clk,
   output logic [7:0] o_sense,
   output logic [7:0] o_ref,
   output logic o_cfg_n,
   output logic o_sel_n
);
   // Idle: points closed, buttons released and pulled up
   initial
   begin
      o_ref = 8'h52;
      o_sense = 8'h10;
      o_cfg_n = 1'b1;
      o_sel_n = 1'b1;
   end
   // Coil level; above the reference means the points are open
   task automatic coil(input logic [7:0] lvl);
      @(posedge i_clk);
      o_sense <= lvl;
   endtask
   // Button level: 0 pressed, 1 released, no bounce modelled
   task automatic button(input logic sel, input logic lvl);
      @(posedge i_clk);
      if (sel)
         o_sel_n <= lvl;
      else
         o_cfg_n <= lvl;
   endtask
endmodule // ipt_partner

// >>> testbench/ipt_top_monitor.sv
// Checker on the top ports of the period timer and display block.
// Assumes one clock domain and the synchronous active high reset.
`timescale 1ns/1ps
module ipt_top_monitor (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic i_config_button_input_n,
   input wire logic [6:0] o_segment_n,
   input wire logic o_digit_one_select,
   input wire logic o_digit_two_select,
   input wire logic o_config_request,
   input wire logic o_config_mode
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // A bus access waits exactly one cycle
   sequence s_start;
      $rose(i_avs_read || i_avs_write);
   endsequence
   sequence s_answer;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   property p_one_wait;
      s_start |-> s_answer;
   endproperty
   property p_idle;
      !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
   endproperty
   property p_one_digit;
      !(o_digit_one_select && o_digit_two_select);
   endproperty
   property p_blank;
      !o_digit_one_select && !o_digit_two_select |-> o_segment_n == 7'h7f;
   endproperty
   property p_first_digit;
      $fell(i_sys_rst) |-> ##[1:2] o_digit_one_select;
   endproperty
   property p_press;
      $fell(i_config_button_input_n) |-> ##[0:2] (o_config_request && o_config_mode);
   endproperty
   property p_mode_hold;
      o_config_mode && !i_avs_write |=> o_config_mode;
   endproperty
   property p_req_hold;
      o_config_request && !i_avs_write |=> o_config_request;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
   a_idle: assert property (p_idle) else $error("wait raised while idle");
   a_one_digit: assert property (p_one_digit) else $error("both digits powered");
   a_blank: assert property (p_blank) else $error("segments lit while dark");
   a_first_digit: assert property (p_first_digit) else $error("no thousands digit");
   a_press: assert property (p_press) else $error("press not taken");
   a_mode_hold: assert property (p_mode_hold) else $error("mode dropped");
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
endmodule // ipt_top_monitor

bind ipt_top ipt_top_monitor u_mon (
   .i_clk(i_clk),
   .i_sys_rst(i_sys_rst),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest),
   .i_config_button_input_n(i_config_button_input_n),
   .o_segment_n(o_segment_n),
   .o_digit_one_select(o_digit_one_select),
   .o_digit_two_select(o_digit_two_select),
   .o_config_request(o_config_request),
   .o_config_mode(o_config_mode)
);

// >>> testbench/test_ipt_top.sv
// Self-checking bench for the period timer and display block.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_ipt_top;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] v;
   wire [31:0] rdat;
   wire [6:0] seg;
   wire [7:0] sense;
   wire [7:0] refv;
   wire wreq, sel1, sel2, lamp, creq, cmode, cfg_n, sel_n;
   int fails = 0;
   int tests_run = 0;
   longint tr;
   // 250 MHz clock
   initial
   begin
      forever #2 i_clk = ~i_clk;
   end
   ipt_partner far (.i_clk(i_clk), .o_sense(sense), .o_ref(refv), .o_cfg_n(cfg_n),
      .o_sel_n(sel_n));
   ipt_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_ignition_sense_input(sense),
      .i_comparator_reference_input(refv), .i_config_button_input_n(cfg_n),
      .i_select_button_input_n(sel_n), .o_segment_n(seg), .o_shift_lamp_output(lamp),
      .o_digit_one_select(sel1), .o_digit_two_select(sel2), .o_config_request(creq),
      .o_config_mode(cmode));
   task automatic give_verdict();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Cycles pass, then outputs are looked at mid-cycle where they are settled
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   // One Avalon access; waitrequest is looked at mid-cycle, before the edge that samples it,
   // and read data is taken at that rising edge, just before the request is released
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (wreq !== 1'b0)
      begin
         fails++;
         give_verdict();
      end
      @(posedge i_clk);
      v = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic disp(input logic [9:0] e);
      cyc(3);
      chk("display", {22'h0, e}, {22'h0, sel1, sel2, lamp, seg});
   endtask
   task automatic t_regs();
      bus(0, 6'h0d, 0);
      chk("flash state reset", 0, v);
      bus(0, 6'h0e, 0);
      chk("upper reset", 0, v);
      bus(1, 6'h0d, 32'hff);
      bus(0, 6'h0d, 0);
      chk("flash state bits", 32'hb8, v);
      bus(1, 6'h3f, 32'h5a);
      bus(0, 6'h3f, 0);
      chk("unmapped", 0, v);
      bus(1, 6'h0d, 0);
   endtask
   task automatic t_clock();
      longint t0;
      int lo;
      int n;
      bus(0, 6'h03, 0);
      lo = v[7:0];
      t0 = $time;
      cyc(80);
      bus(0, 6'h03, 0);
      lo = (v[7:0] - lo) & 255;
      n = ($time - t0) / 32;
      chk("tick rate", 1, lo + 1 >= n && lo <= n + 1);
      bus(1, 6'h0e, 32'h03);
      bus(1, 6'h0f, 32'hff);
      n = 0;
      do
      begin
         bus(0, 6'h0f, 0);
         n++;
      end while (v === 32'hff && n < 1000);
      chk("middle carry", 0, v);
      bus(0, 6'h0e, 0);
      chk("upper carry", 32'h04, v);
      bus(1, 6'h05, 32'h55);
      bus(1, 6'h04, 32'h2a);
      disp({3'b100, 7'h2a});
      bus(1, 6'h0f, 32'h20);
      disp({3'b010, 7'h55});
      bus(1, 6'h0d, 32'h10);
      disp({3'b010, 7'h55});
      bus(1, 6'h0e, 0);
      disp({3'b000, 7'h7f});
      bus(1, 6'h0d, 32'h08);
      disp({3'b010, 7'h55});
      bus(1, 6'h0d, 32'h80);
      disp({3'b011, 7'h55});
      bus(1, 6'h0d, 32'ha0);
      disp({3'b010, 7'h55});
      bus(1, 6'h0f, 32'ha0);
      disp({3'b011, 7'h55});
      bus(1, 6'h0d, 0);
   endtask
   task automatic rise();
      far.coil(8'h10);
      cyc(4);
      far.coil(8'hc0);
      tr = $time;
   endtask
   task automatic meas(input int gap);
      longint t0;
      int e;
      t0 = tr;
      cyc(gap);
      rise();
      e = (tr - t0) / 32;
      cyc(3);
      bus(0, 6'h02, 0);
      chk("period", 1, v + 1 >= e && v <= e + 1);
   endtask
   task automatic t_period();
      far.coil(8'h52);
      cyc(3);
      bus(0, 6'h01, 0);
      chk("equal level", 0, v[6]);
      bus(1, 6'h01, 32'h0f);
      rise();
      cyc(3);
      bus(0, 6'h01, 0);
      chk("start status", 32'h68, v[6:0]);
      bus(1, 6'h01, 32'h0f);
      meas(800);
      bus(0, 6'h01, 0);
      chk("stop status", 32'h69, v[6:0]);
      meas(200);
   endtask
   task automatic t_buttons();
      chk("released", 0, {creq, cmode});
      far.button(0, 0);
      cyc(4);
      chk("config press", 32'h3, {creq, cmode});
      far.button(0, 1);
      far.button(1, 0);
      cyc(3);
      bus(0, 6'h01, 0);
      chk("select pressed", 32'h14, v[4:0] & 5'h14);
      far.button(1, 1);
      cyc(3);
      bus(0, 6'h01, 0);
      chk("select released", 0, v[4]);
      bus(1, 6'h01, 32'h04);
      bus(1, 6'h00, 0);
      cyc(2);
      chk("config cleared", 0, {creq, cmode});
   endtask
   // Mid-run reset: outputs go dark while held, then the thousands digit comes back first
   task automatic t_reset();
      bus(1, 6'h0d, 32'h80);
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      disp({3'b000, 7'h7f});
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      cyc(1);
      chk("reset flags", 0, {creq, cmode});
      disp({3'b100, 7'h7f});
      bus(0, 6'h0d, 0);
      chk("flash state after reset", 0, v);
   endtask
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_clock();
      t_period();
      t_buttons();
      t_reset();
      give_verdict();
   end
endmodule // test_ipt_top
